// >>> design/interrupt_and_flag_control.v
// Interrupt controller with timer and serial control/status registers.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "int_ctl_consts.vh"

// Functional notes
// - Exactly five request sources accepted
// - Vectors 0003h upward, eight bytes apart
// - Pending enabled request forces vectored call
// - High priority preempts low priority routine
// - Global allow clear blocks every interrupt
// - Enable register holds per-source enables
// - Priority register holds per-source priorities
// - Timer overflow flags set, cleared on vector
// - Edge flags set, cleared on vector
// - Type bits select edge or level
// - Run bits switch timers on/off
// - Transmit done set by hardware, software clears
// - Receive done set by hardware, software clears
// - Serial request is OR of done flags
// - Two mode bits select serial mode
// - Multiproc bit drops ninth-bit-zero frames
// - Receive allow bit enables reception
// - Ninth transmit bit; ninth received bit
// - External pins sampled as request inputs
module interrupt_and_flag_control #(
    parameter NUM_SRC = 5
) (
    // Clock and reset.
    input  wire        clk_in,
    input  wire        reset_in,
    // Register port.
    input  wire [1:0]  reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [7:0]  reg_rdata_out,
    // External request pins, active low.
    input  wire        ext0_pin_n_in,
    input  wire        ext1_pin_n_in,
    // Events from timers and serial port.
    input  wire        timer0_ovf_in,
    input  wire        timer1_ovf_in,
    input  wire        tx_byte_sent_in,
    input  wire        rx_byte_in,
    input  wire        rx_ninth_in,
    // Controls to timers and serial port.
    output wire        timer0_run_out,
    output wire        timer1_run_out,
    output wire [1:0]  serial_mode_out,
    output wire        rx_allow_out,
    output wire        tx_ninth_bit_out,
    // CPU core handshake.
    output wire        int_call_out,
    output wire [15:0] int_vector_out,
    input  wire        int_ack_in,
    input  wire        int_return_in
);

    // Source indices in vector order; the pick and the vector clears
    // share them, so the two can never disagree about a source.
    localparam [2:0] SRC_EXT0 = 3'h0;
    localparam [2:0] SRC_TIM0 = 3'h1;
    localparam [2:0] SRC_EXT1 = 3'h2;
    localparam [2:0] SRC_TIM1 = 3'h3;
    localparam [2:0] SRC_SER  = 3'h4;

    // Registers; each control register is one word of flops.
    reg  [7:0] timer_ctl_status_reg_r;
    reg  [7:0] serial_ctl_status_reg_r;
    reg  [7:0] int_enable_register_r;
    reg  [7:0] int_priority_register_r;
    reg        hi_active_r;
    reg        lo_active_r;

    // Decoded fields.
    wire [1:0] pin_n_bus;
    wire [1:0] pin_type;
    wire [1:0] pin_flag;
    wire [1:0] pin_fall;
    wire [1:0] pin_req;
    wire       ext0_fall;
    wire       ext1_fall;
    wire       ext0_req;
    wire       ext1_req;
    wire       rx_accept;
    wire [NUM_SRC-1:0] raw_req;
    wire [NUM_SRC-1:0] en_req;
    wire [NUM_SRC-1:0] hi_req;
    wire [NUM_SRC-1:0] lo_req;
    reg  [2:0] sel_idx;
    reg        sel_hi;
    reg        sel_valid;
    wire       take;
    wire       ack_ext0;
    wire       ack_tim0;
    wire       ack_ext1;
    wire       ack_tim1;
    wire       wr_timer_ctl_status;
    wire       wr_serial_ctl_status;

    // Both request pins share one structure, so one loop builds them.
    // Index 0 is external pin 0 and index 1 is external pin 1; the type
    // and edge flag bits of each pin are gathered beside its pin.
    assign pin_n_bus = {ext1_pin_n_in, ext0_pin_n_in};
    assign pin_type  = {timer_ctl_status_reg_r[`BIT_EXT1_TYPE],
                        timer_ctl_status_reg_r[`BIT_EXT0_TYPE]};
    assign pin_flag  = {timer_ctl_status_reg_r[`BIT_EXT1_EDGE],
                        timer_ctl_status_reg_r[`BIT_EXT0_EDGE]};

    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_pin
            reg [1:0] sync_r;
            reg       prev_r;
            // Pins come from outside the clock domain; two flops before use.
            // Reset loads the idle high level into all three flops, so no
            // false falling edge is seen when reset lets go.
            always @(posedge clk_in) begin
                if (reset_in) begin
                    sync_r <= 2'h3;
                    prev_r <= 1'b1;
                end else begin
                    sync_r <= {sync_r[0], pin_n_bus[p]};
                    prev_r <= sync_r[1];
                end
            end
            // A falling edge is high then low on the second flop.
            assign pin_fall[p] = prev_r & ~sync_r[1];
            // Level mode follows the synchronized pin and is never latched.
            assign pin_req[p]  = pin_type[p] ? pin_flag[p] :
                                 ~sync_r[1];
        end
    endgenerate

    // Named views of the loop outputs for the flag and request logic.
    assign ext0_fall = pin_fall[0];
    assign ext1_fall = pin_fall[1];
    assign ext0_req  = pin_req[0];
    assign ext1_req  = pin_req[1];

    // Source order is the vector order, external 0 at bit 0.
    // The serial source is one request raised by either done flag.
    assign raw_req = {serial_ctl_status_reg_r[`BIT_TX_DONE] |
                      serial_ctl_status_reg_r[`BIT_RX_DONE],
                      timer_ctl_status_reg_r[`BIT_TIMER1_OVF],
                      ext1_req,
                      timer_ctl_status_reg_r[`BIT_TIMER0_OVF],
                      ext0_req};
    // The global allow gates every source before priority splits them.
    assign en_req = raw_req & int_enable_register_r[NUM_SRC-1:0] &
                    {NUM_SRC{int_enable_register_r[`BIT_GLOBAL_ALLOW]}};
    // above
    // A source's priority bit decides which group it joins.
    assign hi_req = en_req & int_priority_register_r[NUM_SRC-1:0];
    assign lo_req = en_req & ~int_priority_register_r[NUM_SRC-1:0];

    // Fixed-order pick; a high request wins over any low one.
    // The lower index wins among equals, so external 0 goes first.
    // A low request waits while either level is open; a high one only
    // waits for an open high level, which is how preemption happens.
    always @* begin
        sel_idx   = SRC_EXT0;
        sel_hi    = 1'b0;
        sel_valid = 1'b0;
        if (|hi_req && !hi_active_r) begin
            sel_hi    = 1'b1;
            sel_valid = 1'b1;
            casez (hi_req)
                5'b????1: sel_idx = SRC_EXT0;
                5'b???10: sel_idx = SRC_TIM0;
                5'b??100: sel_idx = SRC_EXT1;
                5'b?1000: sel_idx = SRC_TIM1;
                default:  sel_idx = SRC_SER;
            endcase
        end else if (|lo_req && !hi_active_r && !lo_active_r) begin
            sel_valid = 1'b1;
            casez (lo_req)
                5'b????1: sel_idx = SRC_EXT0;
                5'b???10: sel_idx = SRC_TIM0;
                5'b??100: sel_idx = SRC_EXT1;
                5'b?1000: sel_idx = SRC_TIM1;
                default:  sel_idx = SRC_SER;
            endcase
        end
    end

    // The core sees a call request and the vector; ack takes it.
    // Both are combinational, so the core may ack in the very cycle in
    // which a flag first shows. The vector idles at the first source's
    // address while no call stands; the core must read it only together
    // with a call. A flag is cleared at the edge that takes its call, so
    // a taken timer or edge-mode source is not offered twice. The serial source has no
    // clear here: its done flags belong to software, and a routine that
    // returns without clearing them is simply called again.
    assign int_call_out   = sel_valid;
    assign int_vector_out = `VEC_BASE +
                            ({13'h0000, sel_idx} << `VEC_STRIDE_SHIFT);
    assign take     = sel_valid & int_ack_in;
    assign ack_ext0 = take & (sel_idx == SRC_EXT0);
    assign ack_tim0 = take & (sel_idx == SRC_TIM0);
    assign ack_ext1 = take & (sel_idx == SRC_EXT1);
    assign ack_tim1 = take & (sel_idx == SRC_TIM1);

    // Active levels; a return closes the highest open level.
    // An ack outranks a return in the same cycle, so a new level is never
    // lost; that return is then ignored and the core must send it again.
    always @(posedge clk_in) begin
        if (reset_in) begin
            hi_active_r <= 1'b0;
            lo_active_r <= 1'b0;
        end else if (take) begin
            if (sel_hi) begin
                hi_active_r <= 1'b1;
            end else begin
                lo_active_r <= 1'b1;
            end
        end else if (int_return_in) begin
            if (hi_active_r) begin
                hi_active_r <= 1'b0;
            end else begin
                lo_active_r <= 1'b0;
            end
        end
    end

    // Write strobes decoded per control register.
    assign wr_timer_ctl_status = reg_wr_in & (reg_addr_in == `ADDR_TIMER_CTL);
    assign wr_serial_ctl_status = reg_wr_in & (reg_addr_in == `ADDR_SERIAL_CTL);
    // Frames with ninth bit zero are dropped while the filter is on.
    // A dropped frame leaves both the done flag and the ninth bit alone,
    // so a filtering receiver never wakes its routine for data bytes.
    assign rx_accept = rx_byte_in &
                       serial_ctl_status_reg_r[`BIT_RX_ALLOW] &
                       ~(serial_ctl_status_reg_r[`BIT_MULTIPROC] &
                         ~rx_ninth_in);

    // Timer control; hardware set wins over a software clear or vectoring.
    // The order of the statements below carries that rule: the later
    // assignment to a bit wins, so the software write comes first, then
    // the vector clears, then the hardware sets. Reordering them would
    // let an overflow in the cycle of a clear be lost.
    always @(posedge clk_in) begin
        if (reset_in) begin
            timer_ctl_status_reg_r <= `RST_TIMER_CTL;
        end else begin
            if (wr_timer_ctl_status) begin
                timer_ctl_status_reg_r <= reg_wdata_in;
            end
            if (ack_tim1) begin
                timer_ctl_status_reg_r[`BIT_TIMER1_OVF] <= 1'b0;
            end
            if (ack_tim0) begin
                timer_ctl_status_reg_r[`BIT_TIMER0_OVF] <= 1'b0;
            end
            if (ack_ext1) begin
                timer_ctl_status_reg_r[`BIT_EXT1_EDGE] <= 1'b0;
            end
            if (ack_ext0) begin
                timer_ctl_status_reg_r[`BIT_EXT0_EDGE] <= 1'b0;
            end
            if (timer1_ovf_in) begin
                timer_ctl_status_reg_r[`BIT_TIMER1_OVF] <= 1'b1;
            end
            if (timer0_ovf_in) begin
                timer_ctl_status_reg_r[`BIT_TIMER0_OVF] <= 1'b1;
            end
            // Edge flags only latch in edge mode, so level mode stays clean.
            if (ext1_fall && timer_ctl_status_reg_r[`BIT_EXT1_TYPE]) begin
                timer_ctl_status_reg_r[`BIT_EXT1_EDGE] <= 1'b1;
            end
            if (ext0_fall && timer_ctl_status_reg_r[`BIT_EXT0_TYPE]) begin
                timer_ctl_status_reg_r[`BIT_EXT0_EDGE] <= 1'b1;
            end
        end
    end

    // Serial control; vectoring leaves the done flags for software.
    // A byte event in the cycle of a software write still sets its flag,
    // so software never loses a completion it has not yet seen.
    always @(posedge clk_in) begin
        if (reset_in) begin
            serial_ctl_status_reg_r <= `RST_SERIAL_CTL;
        end else begin
            if (wr_serial_ctl_status) begin
                serial_ctl_status_reg_r <= reg_wdata_in;
            end
            if (tx_byte_sent_in) begin
                serial_ctl_status_reg_r[`BIT_TX_DONE] <= 1'b1;
            end
            if (rx_accept) begin
                serial_ctl_status_reg_r[`BIT_RX_DONE] <= 1'b1;
                serial_ctl_status_reg_r[`BIT_RX_NINTH] <= rx_ninth_in;
            end
        end
    end

    // Enable and priority registers; reserved bits stay zero.
    // The write masks keep them so, which means reads show zero there and
    // no reserved bit can ever reach the request logic.
    always @(posedge clk_in) begin
        if (reset_in) begin
            int_enable_register_r   <= `RST_INT_ENABLE;
            int_priority_register_r <= `RST_INT_PRIO;
        end else if (reg_wr_in) begin
            if (reg_addr_in == `ADDR_INT_ENABLE) begin
                int_enable_register_r <= reg_wdata_in & `IE_WRITE_MASK;
            end
            if (reg_addr_in == `ADDR_INT_PRIO) begin
                int_priority_register_r <= reg_wdata_in & `IP_WRITE_MASK;
            end
        end
    end

    // Read data stands only in the cycle after the strobe.
    // Returning zero otherwise keeps the bus quiet; a master that samples
    // a cycle late sees zero, never stale data that looks valid.
    // Reads have no side effects: no flag is cleared by reading it.
    always @(posedge clk_in) begin
        if (reset_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `ADDR_TIMER_CTL:  reg_rdata_out <= timer_ctl_status_reg_r;
                `ADDR_SERIAL_CTL: reg_rdata_out <= serial_ctl_status_reg_r;
                `ADDR_INT_ENABLE: reg_rdata_out <= int_enable_register_r;
                default:          reg_rdata_out <= int_priority_register_r;
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // Controls straight from register bits.
    // They follow a write one cycle later, as the registers do.
    assign timer0_run_out   = timer_ctl_status_reg_r[`BIT_TIMER0_RUN];
    assign timer1_run_out   = timer_ctl_status_reg_r[`BIT_TIMER1_RUN];
    assign serial_mode_out  = {serial_ctl_status_reg_r[`BIT_MODE_HI],
                               serial_ctl_status_reg_r[`BIT_MODE_LO]};
    assign rx_allow_out     = serial_ctl_status_reg_r[`BIT_RX_ALLOW];
    assign tx_ninth_bit_out = serial_ctl_status_reg_r[`BIT_TX_NINTH];

endmodule

// >>> design/int_ctl_consts.vh
// Register offsets, field positions, reset values and vectors of the interrupt controller.
`ifndef INT_CTL_CONSTS_VH
`define INT_CTL_CONSTS_VH
`define ADDR_TIMER_CTL     2'h0
`define ADDR_SERIAL_CTL    2'h1
`define ADDR_INT_ENABLE    2'h2
`define ADDR_INT_PRIO      2'h3
`define RST_TIMER_CTL      8'h00
`define RST_SERIAL_CTL     8'h00
`define RST_INT_ENABLE     8'h00
`define RST_INT_PRIO       8'h00
`define BIT_TIMER1_OVF     7
`define BIT_TIMER1_RUN     6
`define BIT_TIMER0_OVF     5
`define BIT_TIMER0_RUN     4
`define BIT_EXT1_EDGE      3
`define BIT_EXT1_TYPE      2
`define BIT_EXT0_EDGE      1
`define BIT_EXT0_TYPE      0
`define BIT_MODE_HI        7
`define BIT_MODE_LO        6
`define BIT_MULTIPROC      5
`define BIT_RX_ALLOW       4
`define BIT_TX_NINTH       3
`define BIT_RX_NINTH       2
`define BIT_TX_DONE        1
`define BIT_RX_DONE        0
`define BIT_GLOBAL_ALLOW   7
`define IE_WRITE_MASK      8'h9f
`define IP_WRITE_MASK      8'h1f
`define VEC_RESET          16'h0000
`define VEC_BASE           16'h0003
`define VEC_STRIDE_SHIFT   3
`endif

// >>> verif/int_ctl_props.sv
// Concurrent checks on the interrupt controller ports.
`timescale 1ns/10ps
module int_ctl_props #(
    parameter NUM_SRC = 5
) (
    // Clock and reset.
    input wire        clk_in,
    input wire        reset_in,
    // Register port.
    input wire [1:0]  reg_addr_in,
    input wire [7:0]  reg_wdata_in,
    input wire        reg_wr_in,
    input wire        reg_rd_in,
    input wire [7:0]  reg_rdata_out,
    // Timer side.
    input wire        timer0_ovf_in,
    input wire        timer0_run_out,
    // CPU core handshake.
    input wire        int_call_out,
    input wire [15:0] int_vector_out,
    input wire        int_ack_in,
    input wire        int_return_in
);
    wire [15:0] ofs  = int_vector_out - 16'h0003;
    wire [12:0] idx  = ofs[15:3];
    wire        take = int_call_out && int_ack_in;
    reg  [4:0]  prio_r;
    reg         hi_r;
    reg         lo_r;
    wire        hi   = prio_r[idx[2:0]];
    // Shadow priorities and active levels; an ack outranks a return.
    always @(posedge clk_in) begin
        if (reset_in)
            prio_r <= 5'h00;
        else if (reg_wr_in && reg_addr_in == 2'h3)
            prio_r <= reg_wdata_in[4:0];
        if (reset_in)
            hi_r <= 1'b0;
        else if (take && hi)
            hi_r <= 1'b1;
        else if (int_return_in)
            hi_r <= 1'b0;
        if (reset_in)
            lo_r <= 1'b0;
        else if (take && !hi)
            lo_r <= 1'b1;
        else if (int_return_in && !hi_r && !take)
            lo_r <= 1'b0;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    property p_rd_idle; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    property p_ie_resv;
        reg_rd_in && reg_addr_in == 2'h2 |=> reg_rdata_out[6:5] == 2'h0;
    endproperty
    a_ie_resv: assert property (p_ie_resv) else $error("reserved bits");
    property p_vec; int_call_out |-> ofs[2:0] == 3'h0 && idx < NUM_SRC; endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_ea_off;
        reg_wr_in && reg_addr_in == 2'h2 && !reg_wdata_in[7] |=> !int_call_out;
    endproperty
    a_ea_off: assert property (p_ea_off) else $error("call when off");
    property p_run;
        reg_wr_in && reg_addr_in == 2'h0 |=>
            timer0_run_out == $past(reg_wdata_in[4]);
    endproperty
    a_run: assert property (p_run) else $error("run bit");
    property p_t0_clr;
        take && int_vector_out == 16'h000b && !timer0_ovf_in |=>
            !(int_call_out && int_vector_out == 16'h000b);
    endproperty
    a_t0_clr: assert property (p_t0_clr) else $error("flag kept");
    property p_hi_blk; hi_r |-> !int_call_out; endproperty
    a_hi_blk: assert property (p_hi_blk) else $error("call in high");
    property p_lo_pre; lo_r && !hi_r && int_call_out |-> hi; endproperty
    a_lo_pre: assert property (p_lo_pre) else $error("low preempts");
endmodule
bind interrupt_and_flag_control int_ctl_props #(.NUM_SRC(NUM_SRC)) u_props (.*);

// >>> verif/cpu_core_model.sv
// CPU core model that takes vectored calls and returns on request.
`timescale 1ns/10ps
module cpu_core_model (
    // Clock and reset.
    input  wire        clk_in,
    input  wire        reset_in,
    // Call from the controller and bench controls.
    input  wire        call_in,
    input  wire [15:0] vector_in,
    input  wire        slow_in,
    input  wire        ret_req_in,
    // Handshake back and record of calls taken.
    output reg         ack_out,
    output reg         ret_out,
    output reg  [15:0] taken_out,
    output reg  [7:0]  count_out
);
    reg [1:0] wait_r;
    // A slow core lets a call stand four cycles before it acks.
    always @(posedge clk_in) begin
        ack_out <= 1'b0;
        ret_out <= ret_req_in & ~reset_in;
        if (reset_in) begin
            wait_r <= 2'h0;
            count_out <= 8'h00;
            taken_out <= 16'h0000;
        end else if (call_in && ack_out) begin
            taken_out <= vector_in;
            count_out <= count_out + 8'h01;
            wait_r <= 2'h0;
        end else if (call_in && (wait_r == 2'h3 || !slow_in)) begin
            ack_out <= 1'b1;
        end else if (call_in) begin
            wait_r <= wait_r + 2'h1;
        end
    end
endmodule

// >>> verif/test_interrupt_and_flag_control.sv
// Self-checking bench for the interrupt and flag controller.
`timescale 1ns/10ps
module test_interrupt_and_flag_control;
    // Stimulus.
    reg         clk_in = 1'b0;
    reg         reset_in = 1'b1;
    reg  [1:0]  reg_addr_in = 2'h0;
    reg  [7:0]  reg_wdata_in = 8'h00;
    reg         reg_wr_in = 1'b0;
    reg         reg_rd_in = 1'b0;
    reg         ext0_pin_n_in = 1'b1;
    reg         ext1_pin_n_in = 1'b1;
    reg  [4:0]  evt = 5'h00;
    reg         slow = 1'b0;
    reg         ret_req = 1'b0;
    wire        timer0_ovf_in = evt[0], timer1_ovf_in = evt[1];
    wire        tx_byte_sent_in = evt[2], rx_byte_in = evt[3];
    wire        rx_ninth_in = evt[4];
    // Observed outputs.
    wire [7:0]  reg_rdata_out;
    wire [1:0]  serial_mode_out;
    wire [15:0] int_vector_out;
    wire [15:0] taken;
    wire [7:0]  cnt;
    wire        timer0_run_out, timer1_run_out, rx_allow_out;
    wire        tx_ninth_bit_out, int_call_out, int_ack_in, int_return_in;
    integer     fails = 0, n_compared = 0, expc = 0, cycles = 0, m;
    interrupt_and_flag_control u_dut (.*);
    cpu_core_model u_cpu (.clk_in(clk_in), .reset_in(reset_in),
        .call_in(int_call_out), .vector_in(int_vector_out), .slow_in(slow),
        .ret_req_in(ret_req), .ack_out(int_ack_in), .ret_out(int_return_in),
        .taken_out(taken), .count_out(cnt));
    // Free-running clock.
    initial forever #12.5 clk_in = ~clk_in;
    task check(input string what, input [15:0] seen, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("FAIL %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task complete_run;
        begin
            $display("compared %0d mismatches %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // Bus cycles keep one idle cycle after each strobe.
    task wr(input [1:0] a, input [7:0] d);
        begin
            reg_addr_in <= a;
            reg_wdata_in <= d;
            reg_wr_in <= 1'b1;
            @(posedge clk_in);
            reg_wr_in <= 1'b0;
            @(posedge clk_in);
        end
    endtask
    task rd(input [1:0] a, input [7:0] e);
        begin
            reg_addr_in <= a;
            reg_rd_in <= 1'b1;
            @(posedge clk_in);
            reg_rd_in <= 1'b0;
            #1 check("rdata", reg_rdata_out, e);
            @(posedge clk_in);
        end
    endtask
    task pulse(input [4:0] v);
        begin
            evt <= v;
            @(posedge clk_in);
            evt <= 5'h00;
            @(posedge clk_in);
        end
    endtask
    task ret;
        begin
            ret_req <= 1'b1;
            @(posedge clk_in);
            ret_req <= 1'b0;
            repeat (3) @(posedge clk_in);
        end
    endtask
    // Waits a bounded time for the core to take one more call.
    task take(input [15:0] v);
        integer i;
        begin
            expc = expc + 1;
            for (i = 0; i < 20 && cnt != expc; i = i + 1) @(posedge clk_in);
            check("vector", taken, v);
            check("count", cnt, expc);
        end
    endtask
    // Hang guard.
    always @(posedge clk_in) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            fails = fails + 1;
            complete_run;
        end
    end
    initial begin
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        for (m = 0; m < 4; m = m + 1) rd(m[1:0], 8'h00);
        wr(2'h2, 8'hff);
        rd(2'h2, 8'h9f);
        wr(2'h3, 8'hff);
        rd(2'h3, 8'h1f);
        wr(2'h3, 8'h00);
        wr(2'h0, 8'h50);
        check("run", {timer1_run_out, timer0_run_out}, 2'h3);
        for (m = 0; m < 4; m = m + 1) begin
            wr(2'h1, {m[1:0], 6'h18});
            check("mode", serial_mode_out, m[1:0]);
        end
        check("ctl", {rx_allow_out, tx_ninth_bit_out}, 2'h3);
        $display("register test done");
        wr(2'h0, 8'h00);
        wr(2'h2, 8'h8a);
        pulse(5'h03);
        take(16'h000b);
        ret;
        take(16'h001b);
        ret;
        wr(2'h3, 8'h08);
        pulse(5'h01);
        take(16'h000b);
        pulse(5'h02);
        take(16'h001b);
        pulse(5'h01);
        ret;
        check("count", cnt, expc);
        ret;
        take(16'h000b);
        ret;
        $display("priority test done");
        wr(2'h2, 8'h0a);
        pulse(5'h01);
        check("call", int_call_out, 1'b0);
        rd(2'h0, 8'h20);
        wr(2'h2, 8'h8a);
        take(16'h000b);
        rd(2'h0, 8'h00);
        ret;
        $display("enable test done");
        slow <= 1'b1;
        wr(2'h1, 8'h10);
        wr(2'h2, 8'h90);
        pulse(5'h04);
        take(16'h0023);
        rd(2'h1, 8'h12);
        wr(2'h1, 8'h10);
        ret;
        pulse(5'h18);
        take(16'h0023);
        rd(2'h1, 8'h15);
        wr(2'h1, 8'hf0);
        ret;
        pulse(5'h08);
        rd(2'h1, 8'hf0);
        slow <= 1'b0;
        $display("serial test done");
        wr(2'h0, 8'h01);
        wr(2'h2, 8'h85);
        ext0_pin_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        ext0_pin_n_in <= 1'b1;
        take(16'h0003);
        rd(2'h0, 8'h01);
        ret;
        ext1_pin_n_in <= 1'b0;
        take(16'h0013);
        ret;
        take(16'h0013);
        ext1_pin_n_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        ret;
        repeat (6) @(posedge clk_in);
        check("count", cnt, expc);
        $display("pin test done");
        complete_run;
    end
endmodule
